// *** logic/acc_pkg.sv ***
// What this block does
// R01 - Comparator active only while enable is one
// R02 - Reference select picks bandgap or positive pin
// R03 - Negative pin always feeds the inverting input
// R04 - Result high when non-inverting input is higher
// R05 - Edge field: 00/10 fall, 01 rise, 11 both
// R06 - Matching edge sets sticky event flag
// R07 - Writing one to flag clears it
// R08 - Interrupt equals enable AND flag
// R09 - Writing zero clears interrupt enable
// R10 - Output bit live, zero when disabled
// R11 - Wait mode: operation and interrupt continue
// R12 - Stop mode: low power, no events
// R13 - Deep stop recovery returns reset state
// R14 - Shallow stop recovery keeps all contents
// R15 - Debug halt: operation continues normally
// R16 - Bandgap selected releases positive pin
// R17 - Output synchronised, edges from successive samples
package acc_pkg;

    localparam logic [7:0] ACC_SC_OFFSET = 8'h00;
    localparam logic [7:0] ACC_SC_RESET  = 8'h00;

    localparam int ACC_BIT_EN   = 7;
    localparam int ACC_BIT_BGS  = 6;
    localparam int ACC_BIT_FLAG = 5;
    localparam int ACC_BIT_IE   = 4;
    localparam int ACC_BIT_OUT  = 3;
    localparam int ACC_MODE_LSB = 0;

    localparam logic [1:0] ACC_MODE_FALL  = 2'h0;
    localparam logic [1:0] ACC_MODE_RISE  = 2'h1;
    localparam logic [1:0] ACC_MODE_FALL2 = 2'h2;
    localparam logic [1:0] ACC_MODE_BOTH  = 2'h3;

    localparam logic [1:0] ACC_STOP1 = 2'h1;
    localparam logic [1:0] ACC_STOP2 = 2'h2;
    localparam logic [1:0] ACC_STOP3 = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } acc_req_t;

    typedef struct packed {
        logic       en;
        logic       bgs;
        logic       flag;
        logic       ie;
        logic [1:0] mode;
    } acc_ctrl_t;

    typedef struct packed {
        acc_ctrl_t  ctrl;
        logic       irq;
        logic       cmp_on;
        logic       ref_sel;
        logic       pin_rel;
        logic [7:0] rdata;
        logic       stop_d;
        logic [1:0] stop_lvl;
    } acc_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic primed;
    } acc_sync_t;

    localparam acc_ctrl_t  ACC_CTRL_RST  = acc_ctrl_t'(ACC_SC_RESET[5:0]);
    localparam acc_state_t ACC_STATE_RST = '{ctrl: ACC_CTRL_RST, rdata: 8'h00,
                                            stop_lvl: 2'h0, default: 1'b0};

    function automatic logic acc_edge_hit(logic [1:0] mode, logic rise, logic fall);
        logic r;
        unique case (mode)
            ACC_MODE_RISE: r = rise;
            ACC_MODE_BOTH: r = rise | fall;
            default:       r = fall;
        endcase
        return r;
    endfunction : acc_edge_hit

    function automatic logic [7:0] acc_pack(acc_ctrl_t c, logic o);
        logic [7:0] v;
        v                       = 8'h00;
        v[ACC_BIT_EN]           = c.en;
        v[ACC_BIT_BGS]          = c.bgs;
        v[ACC_BIT_FLAG]         = c.flag;
        v[ACC_BIT_IE]           = c.ie;
        v[ACC_BIT_OUT]          = o;
        v[ACC_MODE_LSB +: 2]    = c.mode;
        return v;
    endfunction : acc_pack

endpackage : acc_pkg

// *** logic/acc_sync_edge.sv ***
`timescale 1ns/10ps
module acc_sync_edge import acc_pkg::*; (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Control
    input  wire logic clear,
    // Asynchronous comparator result
    input  wire logic raw,
    // Filtered level and edges
    output logic      level,
    output logic      rise,
    output logic      fall
);

    acc_sync_t st_reg;
    acc_sync_t st_next;
    logic      agree;

    assign agree = (st_reg.s2 == st_reg.s3);

    // First agreement after a clear only primes, so no false edge
    assign rise  = st_reg.primed & agree & st_reg.s3 & ~st_reg.level & ~clear; // R17
    assign fall  = st_reg.primed & agree & ~st_reg.s3 & st_reg.level & ~clear; // R17
    assign level = st_reg.level;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (agree) begin
            st_next.level  = st_reg.s3; // R17
            st_next.primed = 1'b1;
        end
        if (clear) begin
            // Disagreeing fill so no prime for two cycles; the third check pairs the first new sample with the low s1 fill
            st_next.s1     = 1'b0;
            st_next.s2     = 1'b1;
            st_next.s3     = 1'b0;
            st_next.level  = 1'b0;
            st_next.primed = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    property p_edge_needs_agree;
        @(posedge mclk) disable iff (!rst_n)
        (rise || fall) |-> (st_reg.s2 == st_reg.s3) && st_reg.primed;
    endproperty
    a_edge_needs_agree: assert property (p_edge_needs_agree) // R17
        else $error("Edge reported without two agreeing samples");

endmodule : acc_sync_edge

// *** logic/acc_ctrl.sv ***
`timescale 1ns/10ps
module acc_ctrl import acc_pkg::*; (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Register port
    input  wire acc_req_t   bus_req,
    output logic [7:0]      rdata,
    // Analog comparator core
    input  wire logic       cmp_raw,
    output logic            cmp_enable,
    output logic            ref_select,
    output logic            pos_pin_release,
    // Low-power control
    input  wire logic       stop_mode,
    input  wire logic [1:0] stop_level,
    // Interrupt request
    output logic            irq
);

    acc_state_t st_reg;
    acc_state_t st_next;
    logic       wr_sc;
    logic       rd_sc;
    logic       hit;
    logic       sync_clear;
    logic       cmp_level;
    logic       cmp_rise;
    logic       cmp_fall;
    logic       out_bit;

    assign wr_sc = bus_req.wr & (bus_req.addr == ACC_SC_OFFSET);
    assign rd_sc = bus_req.rd & (bus_req.addr == ACC_SC_OFFSET);

    // Detector idle exactly while the core is powered down, so stale results never count
    assign sync_clear = ~st_reg.cmp_on; // R01 R12

    // Core result is taken as-is: high means non-inverting above inverting
    acc_sync_edge u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clear (sync_clear),
        .raw   (cmp_raw),       // R04 R17
        .level (cmp_level),
        .rise  (cmp_rise),
        .fall  (cmp_fall)
    );

    // Wait and debug halt do not gate detection or the request
    assign hit = st_reg.ctrl.en & ~stop_mode
               & acc_edge_hit(st_reg.ctrl.mode, cmp_rise, cmp_fall); // R05 R11 R12 R15

    assign out_bit = st_reg.ctrl.en & cmp_level; // R10

    always_comb begin
        st_next        = st_reg;
        st_next.stop_d = stop_mode;
        st_next.rdata  = 8'h00;
        if (stop_mode) begin
            st_next.stop_lvl = stop_level; // R12
        end else if (st_reg.stop_d && st_reg.stop_lvl != ACC_STOP3) begin
            st_next = ACC_STATE_RST; // R13
        end else begin
            // Shallow stop exit falls through with contents kept
            if (wr_sc) begin
                st_next.ctrl.en   = bus_req.wdata[ACC_BIT_EN];   // R01
                st_next.ctrl.bgs  = bus_req.wdata[ACC_BIT_BGS];  // R02
                st_next.ctrl.ie   = bus_req.wdata[ACC_BIT_IE];   // R09
                st_next.ctrl.mode = bus_req.wdata[ACC_MODE_LSB +: 2];
                if (bus_req.wdata[ACC_BIT_FLAG]) begin
                    st_next.ctrl.flag = 1'b0; // R07
                end
            end
            if (hit) begin
                st_next.ctrl.flag = 1'b1; // R06
            end
            if (rd_sc) begin
                st_next.rdata = acc_pack(st_reg.ctrl, out_bit); // R10
            end
        end
        st_next.cmp_on  = st_next.ctrl.en & ~stop_mode;        // R01 R12
        st_next.ref_sel = st_next.ctrl.bgs;                    // R02 R03
        st_next.pin_rel = st_next.ctrl.bgs;                    // R16
        st_next.irq     = st_next.ctrl.ie & st_next.ctrl.flag; // R08
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ACC_STATE_RST;
        end else begin
            st_reg <= st_next; // R14
        end
    end

    assign rdata           = st_reg.rdata;
    assign cmp_enable      = st_reg.cmp_on;
    assign ref_select      = st_reg.ref_sel;
    assign pos_pin_release = st_reg.pin_rel;
    assign irq             = st_reg.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_run;
        !stop_mode && !st_reg.stop_d;
    endsequence

    sequence s_rise_ev;
        s_run ##0 st_reg.ctrl.en && cmp_rise && st_reg.ctrl.mode == ACC_MODE_RISE;
    endsequence

    sequence s_fall_ev;
        s_run ##0 st_reg.ctrl.en && cmp_fall && st_reg.ctrl.mode[0] == 1'b0;
    endsequence

    sequence s_deep_exit;
        st_reg.stop_d && !stop_mode && st_reg.stop_lvl != ACC_STOP3;
    endsequence

    sequence s_shallow_exit;
        st_reg.stop_d && !stop_mode && st_reg.stop_lvl == ACC_STOP3 && !wr_sc && !hit;
    endsequence

    property p_enable_gate;
        !st_reg.ctrl.en |-> !cmp_enable;
    endproperty
    a_enable_gate: assert property (p_enable_gate) // R01
        else $error("Comparator enabled while enable bit is zero");

    property p_ref_and_pin;
        ref_select == st_reg.ctrl.bgs && pos_pin_release == ref_select;
    endproperty
    a_ref_and_pin: assert property (p_ref_and_pin) // R02
        else $error("Reference select or pin release mismatch");

    property p_rise_sets;
        s_rise_ev |=> st_reg.ctrl.flag ##1 st_reg.ctrl.flag || $past(wr_sc);
    endproperty
    a_rise_sets: assert property (p_rise_sets) // R06
        else $error("Rising edge in rise mode did not set flag");

    property p_fall_sets;
        s_fall_ev |=> st_reg.ctrl.flag;
    endproperty
    a_fall_sets: assert property (p_fall_sets) // R05
        else $error("Falling edge in fall mode did not set flag");

    property p_wrong_edge;
        s_run ##0 !st_reg.ctrl.flag && !cmp_fall && st_reg.ctrl.mode == ACC_MODE_FALL
        |=> !st_reg.ctrl.flag;
    endproperty
    a_wrong_edge: assert property (p_wrong_edge) // R05
        else $error("Flag set without a falling edge in fall mode");

    property p_flag_clear;
        s_run ##0 wr_sc && bus_req.wdata[ACC_BIT_FLAG] && !hit |=> !st_reg.ctrl.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R07
        else $error("Write of one did not clear flag");

    property p_irq;
        irq == (st_reg.ctrl.ie && st_reg.ctrl.flag);
    endproperty
    a_irq: assert property (p_irq) // R08
        else $error("Interrupt differs from enable AND flag");

    property p_out_zero;
        s_run ##0 rd_sc && !st_reg.ctrl.en |=> rdata[ACC_BIT_OUT] == 1'b0;
    endproperty
    a_out_zero: assert property (p_out_zero) // R10
        else $error("Output bit read nonzero while disabled");

    property p_stop_hold;
        stop_mode |=> !cmp_enable && st_reg.ctrl.flag == $past(st_reg.ctrl.flag);
    endproperty
    a_stop_hold: assert property (p_stop_hold) // R12
        else $error("Activity during stop mode");

    property p_deep_exit;
        s_deep_exit |=> st_reg.ctrl == ACC_CTRL_RST && !irq ##1 !cmp_enable || $past(wr_sc);
    endproperty
    a_deep_exit: assert property (p_deep_exit) // R13
        else $error("Deep stop exit did not reset the block");

    property p_shallow_exit;
        s_shallow_exit |=> st_reg.ctrl == $past(st_reg.ctrl);
    endproperty
    a_shallow_exit: assert property (p_shallow_exit) // R14
        else $error("Shallow stop exit lost register contents");

endmodule : acc_ctrl

// *** dv/acc_analog_model.sv ***
`timescale 1ns/10ps
module acc_analog_model (
    // Comparator core control
    input  wire logic cmp_enable,
    input  wire logic ref_select,
    // Pin and bandgap voltages in mV
    input  wire integer pos_mv,
    input  wire integer neg_mv,
    input  wire integer bg_mv,
    // Raw result
    output logic      cmp_raw
);
    logic held;

    // A powered-down core gives no valid result, so show the inverse of the last one
    always @* begin
        if (cmp_enable) begin
            cmp_raw = (ref_select ? bg_mv : pos_mv) > neg_mv;
        end else begin
            cmp_raw = ~held;
        end
    end

    always @(cmp_raw) begin
        if (cmp_enable) begin
            held <= cmp_raw;
        end
    end
endmodule : acc_analog_model

// *** dv/tb_analog_comparator_control.sv ***
`timescale 1ns/10ps
module tb_analog_comparator_control import acc_pkg::*;;
    logic       mclk, rst_n, stop_mode, cmp_raw, cmp_enable, ref_select, pos_pin_release, irq;
    logic [1:0] stop_level;
    logic [7:0] rdata, sh;
    logic       fl;
    acc_req_t   req;
    int         pos_mv, neg_mv, bg_mv, error_cnt, n_compared;

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    acc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .bus_req(req), .rdata(rdata),
        .cmp_raw(cmp_raw), .cmp_enable(cmp_enable), .ref_select(ref_select),
        .pos_pin_release(pos_pin_release), .stop_mode(stop_mode),
        .stop_level(stop_level), .irq(irq));
    acc_analog_model pm (.cmp_enable(cmp_enable), .ref_select(ref_select),
        .pos_mv(pos_mv), .neg_mv(neg_mv), .bg_mv(bg_mv), .cmp_raw(cmp_raw));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk

    task automatic results;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge mclk);
        req.wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge mclk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge mclk);
        req.rd   <= 1'b0;
        @(negedge mclk);
        chk("rdata", e & m, rdata & m);
    endtask : rd

    // Drive the pins so the external comparison comes out high or low
    task automatic set_out(input logic hi);
        int n;
        n = 1000 + $urandom % 500;
        @(posedge mclk);
        neg_mv <= n;
        pos_mv <= hi ? n + 1 + $urandom % 500 : n - 1 - $urandom % 500;
    endtask : set_out

    function automatic logic [7:0] exp_rd(input logic [7:0] s);
        logic o;
        o = s[7] & ((s[6] ? bg_mv : pos_mv) > neg_mv);
        return {s[7:4], o, 1'b0, s[1:0]};
    endfunction : exp_rd

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end

    initial begin
        req = '0; stop_mode = 1'b0; stop_level = 2'h0; rst_n = 1'b0;
        pos_mv = 900; neg_mv = 1000; bg_mv = 1200; error_cnt = 0; n_compared = 0;
        void'($urandom(32'h84ea_debc));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h00, 8'h00, 8'hFF);
        wr(8'h00, 8'hD1);
        cyc(1);
        chk("enable", 8'h01, {7'h0, cmp_enable});
        chk("refsel", 8'h01, {7'h0, ref_select});
        chk("release", 8'h01, {7'h0, pos_pin_release});
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h00, 8'hFF);
        rd(8'h00, exp_rd(8'hD1), 8'hFF);
        // Leaving the bandgap makes the output fall: a fall-mode event
        wr(8'h00, 8'h90);
        cyc(6);
        rd(8'h00, 8'hB0, 8'hFF);
        // Every edge mode, rising then falling transition
        for (int m = 0; m < 4; m++) begin
            set_out(1'b0);
            sh = 8'h90 | 8'(m);
            wr(8'h00, sh | 8'h20);
            cyc(6);
            set_out(1'b1);
            cyc(6);
            fl = (m == 1 || m == 3);
            sh[5] = fl;
            rd(8'h00, exp_rd(sh), 8'hFF);
            chk("irq", {7'h0, fl}, {7'h0, irq});
            wr(8'h00, sh | 8'h20);
            sh[5] = 1'b0;
            set_out(1'b0);
            cyc(6);
            fl = (m != 1);
            sh[5] = fl;
            rd(8'h00, exp_rd(sh), 8'hFF);
            chk("irq", {7'h0, fl}, {7'h0, irq});
        end
        wr(8'h00, 8'h83);
        cyc(1);
        chk("irq", 8'h00, {7'h0, irq});
        rd(8'h00, exp_rd(8'hA3), 8'hFF);
        wr(8'h00, 8'hB3);
        rd(8'h00, exp_rd(8'h93), 8'hFF);
        // Bandgap reference against random negative pin levels
        wr(8'h00, 8'hC0);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            neg_mv <= (i % 2) ? 700 + $urandom % 500 : 1201 + $urandom % 500;
            pos_mv <= (i % 2) ? 500 : 2000;
            cyc(6);
            wr(8'h00, 8'hE0);
            rd(8'h00, exp_rd(8'hC0), 8'hFF);
        end
        // Disabled comparator ignores transitions and reads a zero output bit
        wr(8'h00, 8'h13);
        set_out(1'b1);
        cyc(6);
        set_out(1'b0);
        cyc(6);
        chk("enable", 8'h00, {7'h0, cmp_enable});
        rd(8'h00, 8'h13, 8'hFF);
        // Shallow stop keeps state and detects nothing
        wr(8'h00, 8'h93);
        set_out(1'b0);
        cyc(6);
        @(posedge mclk);
        stop_mode  <= 1'b1;
        stop_level <= 2'h3;
        cyc(2);
        chk("enable", 8'h00, {7'h0, cmp_enable});
        set_out(1'b1);
        cyc(6);
        chk("irq", 8'h00, {7'h0, irq});
        set_out(1'b0);
        cyc(2);
        stop_mode <= 1'b0;
        cyc(8);
        chk("enable", 8'h01, {7'h0, cmp_enable});
        rd(8'h00, exp_rd(8'h93), 8'hFF);
        for (int l = 1; l < 3; l++) begin
            wr(8'h00, 8'hD3);
            @(posedge mclk);
            stop_mode  <= 1'b1;
            stop_level <= 2'(l);
            cyc(4);
            stop_mode <= 1'b0;
            cyc(3);
            rd(8'h00, 8'h00, 8'hFF);
            chk("enable", 8'h00, {7'h0, cmp_enable});
        end
        results();
    end
endmodule : tb_analog_comparator_control
